// ### core/sdpsc_core.sv
// clock-enable power-state logic, write masking and register slave of the sdram device
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module sdpsc_core
  import sdpsc_pkg::*;
#(
  parameter int DATA_WIDTH = 16,
  parameter int NONREAD_CLOCKS = SDPSC_SREF_NONREAD_CLOCKS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // command pins sampled at the rising edge
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_bank,
  input wire logic i_a10,
  input wire logic i_termination_enable,
  // write data beats
  input wire logic i_wdata_valid,
  input wire logic i_write_mask,
  input wire logic [DATA_WIDTH-1:0] i_wdata,
  // array write port
  output logic o_array_write,
  output logic [DATA_WIDTH-1:0] o_array_data,
  // state outputs
  output sdpsc_state_type o_power_state,
  output logic [3:0] o_bank_open,
  output logic o_termination_active,
  output logic o_read_allowed,
  output logic o_illegal,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  logic cke_prev;
  logic [1:0] cke_run;
  logic [7:0] sref_cnt;
  logic [31:0] ctrl;
  logic illegal_sticky;

  // command decode
  wire idle_cmd = sdpsc_is_idle_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n);
  wire refresh_cmd = sdpsc_is_refresh(i_cs_n, i_ras_n, i_cas_n, i_we_n);
  wire activate_cmd = ~i_cs_n & ~i_ras_n & i_cas_n & i_we_n;
  wire precharge_cmd = ~i_cs_n & ~i_ras_n & i_cas_n & ~i_we_n;
  wire read_cmd = ~i_cs_n & i_ras_n & ~i_cas_n & i_we_n;
  wire any_open = |o_bank_open;

  // clock-enable edge pairs
  wire pair_hh = cke_prev & i_cke;
  wire pair_hl = cke_prev & ~i_cke;
  wire pair_lh = ~cke_prev & i_cke;
  wire in_normal = (o_power_state == PS_NORMAL);
  wire sref_reject = pair_hl & in_normal & refresh_cmd & any_open;
  wire sref_exit = pair_lh & (o_power_state == PS_SELF_REF);

  sdpsc_state_type next_state;
  always_comb begin
    next_state = o_power_state;
    unique case (o_power_state)
      PS_NORMAL: begin
        if (pair_hl && idle_cmd) begin
          next_state = any_open ? PS_ACT_PD : PS_PRE_PD;
        end else if (pair_hl && refresh_cmd && !any_open) begin
          next_state = PS_SELF_REF;
        end
      end
      // power down keeps rows but runs no refresh
      PS_ACT_PD, PS_PRE_PD, PS_SELF_REF: begin
        // low twice holds regardless of command pins
        if (pair_lh) begin
          next_state = PS_NORMAL;
        end
      end
    endcase
  end

  // bank row tracking, only with enable high on both edges
  logic [3:0] next_bank_open;
  always_comb begin
    next_bank_open = o_bank_open;
    if (pair_hh && in_normal && activate_cmd) begin
      next_bank_open[i_bank] = 1'b1;
    end else if (pair_hh && in_normal && precharge_cmd) begin
      if (i_a10) begin
        next_bank_open = 4'h0;
      end else begin
        next_bank_open[i_bank] = 1'b0;
      end
    end
  end

  // self refresh exit counter, saturates at the read delay
  wire [7:0] next_sref_cnt = sref_exit ? 8'h00 :
    (sref_cnt == 8'(SDPSC_SREF_READ_CLOCKS)) ? sref_cnt : sref_cnt + 8'h01;
  wire read_ok_next = (next_sref_cnt == 8'(SDPSC_SREF_READ_CLOCKS));
  wire in_exit_window = (sref_cnt < 8'(NONREAD_CLOCKS)) & ~read_ok_next;

  // protocol violations seen at the pins
  wire bad_pd_cmd = (pair_hl & in_normal & ~idle_cmd & ~refresh_cmd)
    | (pair_lh & ~in_normal & ~idle_cmd);
  wire bad_exit_cmd = pair_hh & in_normal & in_exit_window & ~idle_cmd;
  wire bad_early_read = pair_hh & in_normal & read_cmd & ~o_read_allowed;
  wire bad_dwell = (cke_prev != i_cke) & (cke_run < 2'(SDPSC_CKE_MIN_CLOCKS));
  wire next_illegal = bad_pd_cmd | bad_exit_cmd | bad_early_read | bad_dwell | sref_reject;
  wire [1:0] next_cke_run = (cke_prev != i_cke) ? 2'h1 :
    (cke_run == 2'(SDPSC_CKE_MIN_CLOCKS)) ? cke_run : cke_run + 2'h1;

  // termination never active in self refresh
  wire next_term = i_termination_enable & ctrl[SDPSC_CTRL_TERM_BIT]
    & (next_state != PS_SELF_REF);

  // register slave, one wait cycle per access
  wire bus_req = i_avs_read | i_avs_write;
  wire write_fire = i_avs_write & ~o_avs_waitrequest;
  wire ctrl_hit = (i_avs_address == SDPSC_CTRL_OFFSET);
  wire status_hit = (i_avs_address == SDPSC_STATUS_OFFSET);
  wire clear_req = write_fire & ctrl_hit & i_avs_writedata[SDPSC_CTRL_CLEAR_BIT];
  wire [31:0] status_word = {21'h0, o_termination_active, o_read_allowed, illegal_sticky,
    o_bank_open, o_power_state};
  wire [31:0] read_mux = ctrl_hit ? ctrl : status_hit ? status_word : 32'h0;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cke_prev <= 1'b1;
      cke_run <= 2'(SDPSC_CKE_MIN_CLOCKS);
      o_power_state <= PS_NORMAL;
      o_bank_open <= 4'h0;
      sref_cnt <= 8'(SDPSC_SREF_READ_CLOCKS);
      o_read_allowed <= 1'b1;
      o_illegal <= 1'b0;
      o_termination_active <= 1'b0;
    end else begin
      cke_prev <= i_cke;
      cke_run <= next_cke_run;
      o_power_state <= next_state;
      o_bank_open <= next_bank_open;
      sref_cnt <= next_sref_cnt;
      o_read_allowed <= read_ok_next;
      o_illegal <= next_illegal;
      o_termination_active <= next_term;
    end
  end

  // write beats: mask high inhibits, mask low stores
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_array_write <= 1'b0;
      o_array_data <= '0;
    end else begin
      o_array_write <= i_wdata_valid & ~i_write_mask;
      o_array_data <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl <= SDPSC_CTRL_RESET;
      illegal_sticky <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end else begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= read_mux;
      end
      if (write_fire && ctrl_hit) begin
        ctrl <= {31'h0, i_avs_writedata[SDPSC_CTRL_TERM_BIT]};
      end
      // a new violation wins over a clear in the same cycle
      if (next_illegal) begin
        illegal_sticky <= 1'b1;
      end else if (clear_req) begin
        illegal_sticky <= 1'b0;
      end
    end
  end

  // checks
  a_active_pd_entry: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_hl && in_normal && idle_cmd && any_open) |=> (o_power_state == PS_ACT_PD)
      && ($past(o_bank_open) == o_bank_open))
    else $error("active power down not entered with rows kept");

  a_precharge_pd_entry: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_hl && in_normal && idle_cmd && !any_open) |=> (o_power_state == PS_PRE_PD))
    else $error("precharge power down not entered");

  a_sref_entry_ok: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_hl && in_normal && refresh_cmd && !any_open) |=> (o_power_state == PS_SELF_REF))
    else $error("self refresh not entered from idle");

  a_sref_entry_reject: assert property (@(posedge i_clock) disable iff (i_rst)
    sref_reject |=> (o_power_state == PS_NORMAL) && o_illegal)
    else $error("self refresh entry with open rows not rejected");

  a_low_pair_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    (!cke_prev && !i_cke && !in_normal) |=> $stable(o_power_state))
    else $error("power state left while clock enable stayed low");

  a_pd_exit: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_lh && !in_normal) |=> (o_power_state == PS_NORMAL))
    else $error("power state not left on clock enable rise");

  // clocks since the last self refresh exit, saturating
  logic [7:0] exit_age;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      exit_age <= 8'hff;
    end else if (sref_exit) begin
      exit_age <= 8'h00;
    end else if (exit_age != 8'hff) begin
      exit_age <= exit_age + 8'h01;
    end
  end

  a_sref_read_delay: assert property (@(posedge i_clock) disable iff (i_rst)
    (exit_age == 8'(SDPSC_SREF_READ_CLOCKS)) |-> o_read_allowed)
    else $error("read not allowed after self refresh read delay");

  a_sref_read_block: assert property (@(posedge i_clock) disable iff (i_rst)
    sref_exit |=> !o_read_allowed [*8])
    else $error("read allowed too early after self refresh exit");

  a_term_off_sref: assert property (@(posedge i_clock) disable iff (i_rst)
    o_termination_active |-> (o_power_state != PS_SELF_REF))
    else $error("termination active in self refresh");

  a_mask_blocks: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_wdata_valid && i_write_mask) |=> !o_array_write)
    else $error("masked beat written");

  a_unmask_stores: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_wdata_valid && !i_write_mask) |=> o_array_write && (o_array_data == $past(i_wdata)))
    else $error("unmasked beat not stored");

  a_dwell_flag: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_hl ##1 pair_lh) |=> o_illegal)
    else $error("short clock enable pulse not flagged");

  a_bus_answer: assert property (@(posedge i_clock) disable iff (i_rst)
    (bus_req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle after request");

  a_high_pair_stay: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_hh && in_normal) |=> (o_power_state == PS_NORMAL))
    else $error("power state left with clock enable high twice");

  a_bank_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    !(pair_hh && in_normal && (activate_cmd || precharge_cmd)) |=> $stable(o_bank_open))
    else $error("open rows changed without activate or precharge");

  a_early_read_flag: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_hh && in_normal && read_cmd && !o_read_allowed) |=> o_illegal)
    else $error("early read after self refresh not flagged");

  a_entry_bad_cmd: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_hl && in_normal && !idle_cmd && !refresh_cmd) |=> (o_power_state == PS_NORMAL)
      && o_illegal)
    else $error("power down entry with a command not refused");

  a_exit_cmd_flag: assert property (@(posedge i_clock) disable iff (i_rst)
    (pair_lh && !in_normal && !idle_cmd) |=> (o_power_state == PS_NORMAL) && o_illegal)
    else $error("exit with a command not flagged");

  a_wait_idle: assert property (@(posedge i_clock) disable iff (i_rst)
    !bus_req |=> o_avs_waitrequest)
    else $error("waitrequest low without a request");

endmodule

`default_nettype wire

// ### core/sdpsc_pkg.sv
// constants, types and decode helpers for the sdram power-state control block
package sdpsc_pkg;

  // register byte offsets
  localparam logic [3:0] SDPSC_CTRL_OFFSET = 4'h0;
  localparam logic [3:0] SDPSC_STATUS_OFFSET = 4'h4;

  // control field positions and reset value
  localparam int SDPSC_CTRL_TERM_BIT = 0;
  localparam int SDPSC_CTRL_CLEAR_BIT = 1;
  localparam logic [31:0] SDPSC_CTRL_RESET = 32'h0000_0001;

  // status field positions
  localparam int SDPSC_STAT_STATE_LSB = 0;
  localparam int SDPSC_STAT_BANK_LSB = 4;
  localparam int SDPSC_STAT_ILLEGAL_BIT = 8;
  localparam int SDPSC_STAT_READ_OK_BIT = 9;
  localparam int SDPSC_STAT_TERM_BIT = 10;

  // timing counts in clocks
  localparam int SDPSC_SREF_READ_CLOCKS = 200;
  localparam int SDPSC_SREF_NONREAD_CLOCKS = 10;
  localparam int SDPSC_CKE_MIN_CLOCKS = 3;

  typedef enum logic [3:0] {
    PS_NORMAL = 4'h1,
    PS_ACT_PD = 4'h2,
    PS_PRE_PD = 4'h4,
    PS_SELF_REF = 4'h8
  } sdpsc_state_type;

  // no-operation or deselect at this edge
  function automatic logic sdpsc_is_idle_cmd(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
    return cs_n | (ras_n & cas_n & we_n);
  endfunction

  // refresh command (also self refresh entry when clock enable falls)
  function automatic logic sdpsc_is_refresh(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    return ~cs_n & ~ras_n & ~cas_n & we_n;
  endfunction

endpackage

// ### dv/sdpsc_ctl.sv
// memory-controller model driving clock enable and command pins
`timescale 1ns/1ps
`default_nettype none

module sdpsc_ctl (
  // clock
  input wire logic i_clock,
  // command pins, {cs_n, ras_n, cas_n, we_n}
  output logic o_cke,
  output logic [3:0] o_cmd,
  output logic [1:0] o_bank,
  output logic o_a10
);
  int held = 3;
  // level already scheduled on the pin, so back to back calls see it
  logic level = 1'b1;

  // defined levels from time zero
  initial begin
    o_cke = 1'b1;
    o_cmd = 4'h7;
    o_bank = 2'h0;
    o_a10 = 1'b0;
  end

  // one command per edge; a level change waits for three edges at the old level
  task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] b, input logic a);
    while (k !== level && held < 3) begin
      @(posedge i_clock);
      o_cmd <= 4'h7;
      held++;
    end
    @(posedge i_clock);
    held = (k === level) ? held + 1 : 1;
    level = k;
    o_cke <= k;
    o_cmd <= c;
    o_bank <= b;
    o_a10 <= a;
  endtask
endmodule

`default_nettype wire

// ### dv/sdpsc_core_bench.sv
// self-checking bench of the sdram power-state control block
`timescale 1ns/1ps
`default_nettype none

module sdpsc_core_bench;
  import sdpsc_pkg::*;
  localparam logic [3:0] NOP = 4'h7;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] REF = 4'h1;
  localparam logic [3:0] RD = 4'h5;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic term = 1'b0;
  logic valid = 1'b0;
  logic mask = 1'b0;
  logic [15:0] wdata = 16'h0;
  logic [3:0] addr = 4'h0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdv;
  wire logic cke, a10, aw, tact, rok, ill, wreq;
  wire logic [3:0] cmd, bopen;
  wire logic [1:0] bank;
  wire logic [15:0] adata;
  wire logic [31:0] rdata;
  wire sdpsc_state_type pst;
  int fails = 0;
  int total_checks = 0;

  sdpsc_ctl sdpsc_ctl_i (.i_clock(i_clock), .o_cke(cke), .o_cmd(cmd), .o_bank(bank), .o_a10(a10));

  sdpsc_core sdpsc_core_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_cke(cke), .i_cs_n(cmd[3]), .i_ras_n(cmd[2]),
    .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_bank(bank), .i_a10(a10), .i_termination_enable(term),
    .i_wdata_valid(valid), .i_write_mask(mask), .i_wdata(wdata), .o_array_write(aw),
    .o_array_data(adata), .o_power_state(pst), .o_bank_open(bopen), .o_termination_active(tact),
    .o_read_allowed(rok), .o_illegal(ill), .i_avs_address(addr), .i_avs_read(rd_q),
    .i_avs_write(wr_q), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));

  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cm(input logic k, input logic [3:0] c, input logic [1:0] b = 2'h0,
                    input logic a = 1'b0);
    sdpsc_ctl_i.issue(k, c, b, a);
  endtask

  task automatic look;
    @(posedge i_clock);
    #1;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    rd_q <= !w;
    wr_q <= w;
    addr <= a;
    wd <= d;
    do begin
      @(posedge i_clock);
    end while (wreq !== 1'b0);
    rdv = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask

  task automatic t_regs;
    bus(1'b0, SDPSC_STATUS_OFFSET, 32'h0);
    chk(rdv, 32'h0000_0201);
    bus(1'b0, SDPSC_CTRL_OFFSET, 32'h0);
    chk(rdv, SDPSC_CTRL_RESET);
    bus(1'b1, SDPSC_CTRL_OFFSET, 32'h0);
    bus(1'b0, SDPSC_CTRL_OFFSET, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b1, SDPSC_CTRL_OFFSET, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    chk(rdv, 32'h0);
  endtask

  task automatic t_pre_pd;
    cm(1'b0, NOP);
    cm(1'b0, REF);
    cm(1'b0, ACT);
    look;
    chk(pst, PS_PRE_PD);
    chk(ill, 1'b0);
    cm(1'b1, NOP);
    look;
    chk(pst, PS_NORMAL);
  endtask

  task automatic t_act_pd;
    cm(1'b1, ACT, 2'h1);
    cm(1'b1, NOP);
    cm(1'b0, NOP);
    cm(1'b0, NOP);
    look;
    chk(pst, PS_ACT_PD);
    cm(1'b1, NOP);
    look;
    chk({pst, bopen}, {PS_NORMAL, 4'h2});
    cm(1'b0, REF);
    look;
    chk({pst, 3'h0, ill}, {PS_NORMAL, 4'h1});
    cm(1'b1, NOP);
    bus(1'b0, SDPSC_STATUS_OFFSET, 32'h0);
    chk(rdv[8], 1'b1);
    bus(1'b1, SDPSC_CTRL_OFFSET, 32'h3);
    bus(1'b0, SDPSC_STATUS_OFFSET, 32'h0);
    chk(rdv[8], 1'b0);
    cm(1'b1, PRE, 2'h0, 1'b1);
    cm(1'b1, NOP);
    look;
    chk(bopen, 4'h0);
  endtask

  task automatic t_self_ref;
    @(posedge i_clock);
    term <= 1'b1;
    cm(1'b0, REF);
    cm(1'b0, NOP);
    look;
    chk({pst, 3'h0, tact}, {PS_SELF_REF, 4'h0});
    cm(1'b1, NOP);
    look;
    chk({pst, 2'h0, tact, rok}, {PS_NORMAL, 4'h2});
    repeat (SDPSC_SREF_READ_CLOCKS - 20) @(posedge i_clock);
    chk(rok, 1'b0);
    cm(1'b1, RD);
    look;
    chk(ill, 1'b1);
    cm(1'b1, NOP);
    repeat (40) @(posedge i_clock);
    chk(rok, 1'b1);
    cm(1'b1, RD);
    look;
    chk(ill, 1'b0);
    cm(1'b1, NOP);
  endtask

  // refused entry, command on exit and a short enable pulse are flagged
  task automatic t_flags;
    cm(1'b0, ACT);
    look;
    chk({pst, 3'h0, ill}, {PS_NORMAL, 4'h1});
    cm(1'b1, NOP);
    cm(1'b0, NOP);
    cm(1'b1, REF);
    look;
    chk({pst, 3'h0, ill}, {PS_NORMAL, 4'h1});
    cm(1'b0, NOP);
    // skip the dwell guard for a one-edge low pulse
    sdpsc_ctl_i.held = 3;
    cm(1'b1, NOP);
    look;
    chk({pst, 3'h0, ill}, {PS_NORMAL, 4'h1});
  endtask

  task automatic beat(input logic m, input logic [15:0] d);
    @(posedge i_clock);
    valid <= 1'b1;
    mask <= m;
    wdata <= d;
    @(posedge i_clock);
    valid <= 1'b0;
    #1;
    chk(aw, !m);
    if (!m) chk(adata, d);
  endtask

  initial begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs;
    t_pre_pd;
    t_act_pd;
    t_self_ref;
    beat(1'b0, 16'ha5c3);
    beat(1'b1, 16'h5a3c);
    t_flags;
    conclude;
  end

  initial begin
    repeat (3000) @(posedge i_clock);
    fails++;
    conclude;
  end
endmodule

`default_nettype wire
